// file: verilog/eerr_ecc_response.sv
// ECC event response: core exception selection, machine check syndrome,
// address and return capture, and the error status capture with combined interrupt.
// Assumes events arrive as one-cycle pulses synchronous to clk.
`timescale 1ns/10ps
// Summary of operation
// RL1: First-class cores: single-bit corrected silently, no report.
// RL2: First-class, interrupts off: checkstop or machine check.
// RL3: First-class, interrupts on: data/instruction storage exception.
// RL4: Second-class: uncorrectable always machine check.
// RL5: Handler must clear syndrome flags, else recall.
// RL6: Second-class: single-bit corrected, optionally reported.
// RL7: Enabled events raise combined external interrupt.
// RL8: Non-core master: interrupt only, no exception.
// RL9: Core master: interrupt plus exception, by priority.
// RL10: Flash uncorrectable: invalidate page or doubleword.
// RL11: Line fill with uncorrectable error invalidates line.
// RL12: Corrupt read sets address-valid, load, data-read.
// RL13: Sub-word write sets also write bus error.
// RL14: Fetch sets address-valid, fetch, instruction-read.
// RL15: Line fill sets address-valid plus read error.
// RL16: Address captured only while address-valid clear.
// RL17: Address mode picks effective or physical address.
// RL18: Second-class return register holds faulting instruction.
// RL19: Software advances return by 4 or 2.
// RL20: Status module records last event, any master.
// RL21: Four separate RAM/flash corrected/uncorrectable flags.
// RL22: Software rereads status until two reads match.
// RL23: Write-one clears flag; 0x33 clears all.
module eerr_ecc_response
    import eerr_pkg::*;
#(
    parameter bit SECOND_CLASS = 1'b0,
    parameter bit PAGE_INVALIDATE = 1'b1
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire eerr_event_s eccEvent,
    input wire logic external_interrupt_enable,
    input wire logic machine_check_enable,
    input wire logic singleBitReportEnable,
    input wire logic ramReportEnable,
    input wire logic flashReportEnable,
    input wire logic addressModeSet,
    input wire logic [7:0] statusClearMask,
    input wire logic statusClearWrite,
    input wire eerr_syndrome_s syndromeClear,
    output logic checkstop,
    output logic machineCheckReq,
    output logic dataStorageReq,
    output logic instructionStorageReq,
    output logic externalTermination,
    output logic combinedIrq,
    output logic invalidateReq,
    output logic [ADDR_W-1:0] invalidateBase,
    output logic [ADDR_W-1:0] invalidateMask,
    output eerr_syndrome_s machine_check_syndrome,
    output logic [ADDR_W-1:0] machine_check_address,
    output logic [ADDR_W-1:0] machine_check_return_address,
    output logic [ADDR_W-1:0] save_restore_address,
    output logic [7:0] eccStatus,
    output logic [ADDR_W-1:0] ramErrAddr,
    output logic [7:0] ramErrMaster,
    output logic [7:0] ramErrAttr,
    output logic [ADDR_W-1:0] flashErrAddr,
    output logic [7:0] flashErrMaster,
    output logic [7:0] flashErrAttr
);
    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    wire logic fromCore = eccEvent.master == CORE_MASTER_ID;
    wire logic uncorr = eccEvent.valid && eccEvent.multiBit;
    wire logic coreUncorr = uncorr && fromCore; // RL8
    wire logic isFetch = eccEvent.access == EERR_ACC_FETCH;
    wire logic isWrite = eccEvent.access == EERR_ACC_WRITE;
    wire logic isFill = eccEvent.access == EERR_ACC_LINEFILL;
    wire logic fillInstr = isFill && !eccEvent.isDataFill;
    wire logic instrKind = isFetch || fillInstr;
    // Single-bit events reach the status module only on second-class cores
    wire logic singleRep = eccEvent.valid && !eccEvent.multiBit && SECOND_CLASS && singleBitReportEnable; // RL1 RL6
    wire logic reportable = uncorr || singleRep;
    wire logic ramEv = reportable && !eccEvent.isFlash && ramReportEnable;
    wire logic flashEv = reportable && eccEvent.isFlash && flashReportEnable;

    // Exception selection
    wire logic mcTake = SECOND_CLASS ? coreUncorr : (coreUncorr && !external_interrupt_enable && machine_check_enable); // RL2 RL4
    wire logic csTake = !SECOND_CLASS && coreUncorr && !external_interrupt_enable && !machine_check_enable; // RL2
    wire logic dsTake = !SECOND_CLASS && coreUncorr && external_interrupt_enable && !instrKind; // RL3
    wire logic isTake = !SECOND_CLASS && coreUncorr && external_interrupt_enable && instrKind; // RL3
    // With machine check disabled on second-class cores the syndrome flags stay untouched
    wire logic synUpdate = coreUncorr && (!SECOND_CLASS || machine_check_enable); // RL4
    wire logic pendingFlags = machine_check_syndrome.dataReadBusError || machine_check_syndrome.writeBusError
        || machine_check_syndrome.instructionReadBusError;
    // Uncleared flags re-raise machine check
    wire logic mcRecall = SECOND_CLASS && machine_check_enable && pendingFlags; // RL5

    // Syndrome flags to set for this event
    eerr_syndrome_s synSet;
    assign synSet.addressValid = synUpdate; // RL12 RL14 RL15
    assign synSet.addressMode = 1'b0;
    assign synSet.loadFlag = synUpdate && (eccEvent.access == EERR_ACC_READ || isWrite); // RL12 RL13
    assign synSet.fetchFlag = synUpdate && isFetch; // RL14
    assign synSet.dataReadBusError = synUpdate && !instrKind; // RL12 RL13 RL15
    assign synSet.writeBusError = synUpdate && isWrite; // RL13
    assign synSet.instructionReadBusError = synUpdate && instrKind; // RL14 RL15

    // A clear in the same cycle frees the address register for this event
    wire logic addrLoad = synUpdate && (!machine_check_syndrome.addressValid || syndromeClear.addressValid); // RL16
    wire logic [ADDR_W-1:0] capAddr = addressModeSet ? eccEvent.effAddr : eccEvent.physAddr; // RL17

    // Invalidate region
    wire logic [ADDR_W-1:0] pageMask = ~((ADDR_W)'((PAGE_BITS / 8) - 1));
    wire logic [ADDR_W-1:0] dwMask = ~((ADDR_W)'((DWORD_BITS / 8) - 1));
    wire logic [ADDR_W-1:0] lineMask = ~((ADDR_W)'(LINE_BYTES - 1));
    wire logic [ADDR_W-1:0] flashMask = PAGE_INVALIDATE ? pageMask : dwMask; // RL10
    wire logic [ADDR_W-1:0] invMaskD = isFill ? lineMask : flashMask; // RL11
    wire logic invTake = uncorr && (eccEvent.isFlash || isFill);

    // Status flags: set wins over write-one clear
    logic [7:0] statusSet;
    assign statusSet = ((8)'(flashEv && eccEvent.multiBit) << FLG_FLASH_NONCORRECTABLE_FLAG_BIT)
        | ((8)'(flashEv && !eccEvent.multiBit) << FLG_FLASH_SINGLE_CORRECTED_FLAG_BIT)
        | ((8)'(ramEv && eccEvent.multiBit) << FLG_RAM_NONCORRECTABLE_FLAG_BIT)
        | ((8)'(ramEv && !eccEvent.multiBit) << FLG_RAM_SINGLE_CORRECTED_FLAG_BIT); // RL21
    wire logic [7:0] clrBits = statusClearWrite ? (statusClearMask & FLG_ALL_MASK) : 8'h00; // RL23
    wire logic [7:0] statusD = ((eccStatus & ~clrBits) | statusSet) & FLG_ALL_MASK; // RL23

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            checkstop <= 1'b0;
            machineCheckReq <= 1'b0;
            dataStorageReq <= 1'b0;
            instructionStorageReq <= 1'b0;
            externalTermination <= 1'b0;
            invalidateReq <= 1'b0;
            invalidateBase <= '0;
            invalidateMask <= '0;
        end
        else
        begin
            checkstop <= checkstop || csTake; // RL2
            machineCheckReq <= mcTake || mcRecall; // RL4 RL5 RL9
            dataStorageReq <= dsTake; // RL3
            instructionStorageReq <= isTake; // RL3
            externalTermination <= dsTake ? 1'b1 : (coreUncorr ? 1'b0 : externalTermination); // RL3
            invalidateReq <= invTake; // RL10 RL11
            invalidateBase <= invTake ? (eccEvent.physAddr & invMaskD) : invalidateBase;
            invalidateMask <= invTake ? invMaskD : invalidateMask;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            machine_check_syndrome <= '0;
            machine_check_address <= '0;
            machine_check_return_address <= '0;
            save_restore_address <= '0;
        end
        else
        begin
            machine_check_syndrome <= (machine_check_syndrome & ~syndromeClear) | synSet;
            machine_check_syndrome.addressMode <= addressModeSet; // RL17
            if (addrLoad)
                machine_check_address <= capAddr; // RL16 RL17
            if (coreUncorr && SECOND_CLASS)
                machine_check_return_address <= eccEvent.instAddr; // RL18
            if (coreUncorr && !SECOND_CLASS)
                save_restore_address <= eccEvent.instAddr; // RL18
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            eccStatus <= STATUS_RESET;
            combinedIrq <= 1'b0;
            ramErrAddr <= '0;
            ramErrMaster <= '0;
            ramErrAttr <= '0;
            flashErrAddr <= '0;
            flashErrMaster <= '0;
            flashErrAttr <= '0;
        end
        else
        begin
            eccStatus <= statusD;
            combinedIrq <= |statusD; // RL7 RL8 RL9
            if (ramEv)
            begin
                ramErrAddr <= eccEvent.physAddr; // RL20
                ramErrMaster <= eccEvent.master;
                ramErrAttr <= eccEvent.attr;
            end
            if (flashEv)
            begin
                flashErrAddr <= eccEvent.physAddr; // RL20
                flashErrMaster <= eccEvent.master;
                flashErrAttr <= eccEvent.attr;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence coreHit;
        eccEvent.valid && eccEvent.multiBit && eccEvent.master == CORE_MASTER_ID;
    endsequence

    chk_single_silent: assert property (@(posedge clk) disable iff (!reset_n) // RL1
        (eccEvent.valid && !eccEvent.multiBit && !SECOND_CLASS) |=> !machineCheckReq && $stable(eccStatus) || $fell(reset_n))
        else $error("single-bit event produced a report");
    chk_ds_external: assert property (@(posedge clk) disable iff (!reset_n) // RL3
        (coreHit and (!SECOND_CLASS && external_interrupt_enable && !instrKind)) |=> dataStorageReq && externalTermination)
        else $error("data storage exception missing");
    chk_mc_second: assert property (@(posedge clk) disable iff (!reset_n) // RL4
        (coreHit and SECOND_CLASS) |=> machineCheckReq)
        else $error("machine check missing on second-class core");
    chk_dma_noexc: assert property (@(posedge clk) disable iff (!reset_n) // RL8
        (uncorr && !fromCore && !mcRecall) |=> !machineCheckReq && !dataStorageReq && !instructionStorageReq)
        else $error("non-core master raised core exception");
    chk_irq_follows: assert property (@(posedge clk) disable iff (!reset_n) // RL7
        (ramEv || flashEv) |=> combinedIrq)
        else $error("combined interrupt not raised");
    chk_addr_hold: assert property (@(posedge clk) disable iff (!reset_n) // RL16
        (machine_check_syndrome.addressValid && !syndromeClear.addressValid) |=> $stable(machine_check_address))
        else $error("address overwritten while valid");
    chk_write_flags: assert property (@(posedge clk) disable iff (!reset_n) // RL13
        (coreHit and (isWrite && !SECOND_CLASS)) |=> machine_check_syndrome.writeBusError
            && machine_check_syndrome.loadFlag && machine_check_syndrome.dataReadBusError)
        else $error("write error syndrome incomplete");
    chk_clear_all: assert property (@(posedge clk) disable iff (!reset_n) // RL23
        (statusClearWrite && statusClearMask == FLG_ALL_MASK && !ramEv && !flashEv) |=> eccStatus == STATUS_RESET)
        else $error("status not cleared");
    chk_fetch_flags: assert property (@(posedge clk) disable iff (!reset_n) // RL14
        (coreHit and (isFetch && !SECOND_CLASS)) |=> machine_check_syndrome.fetchFlag
            && machine_check_syndrome.instructionReadBusError && machine_check_syndrome.addressValid)
        else $error("fetch syndrome incomplete");

    // ----------------------------------------------------------------
    // Further checks
    // ----------------------------------------------------------------
    sequence fillHit;
        uncorr && isFill;
    endsequence

    sequence flashHit;
        uncorr && eccEvent.isFlash && !isFill;
    endsequence

    chk_cs_sticky: assert property (@(posedge clk) disable iff (!reset_n) // RL2
        checkstop |=> checkstop)
        else $error("checkstop left without reset");
    chk_cs_enter: assert property (@(posedge clk) disable iff (!reset_n) // RL2
        (coreHit and (!SECOND_CLASS && !external_interrupt_enable && !machine_check_enable)) |=> checkstop)
        else $error("checkstop not entered");
    chk_mc_first: assert property (@(posedge clk) disable iff (!reset_n) // RL2
        (coreHit and (!SECOND_CLASS && !external_interrupt_enable && machine_check_enable)) |=> machineCheckReq)
        else $error("machine check missing on first-class core");
    chk_is_fetch: assert property (@(posedge clk) disable iff (!reset_n) // RL3
        (coreHit and (!SECOND_CLASS && external_interrupt_enable && instrKind)) |=> instructionStorageReq)
        else $error("instruction storage exception missing");
    chk_recall_mc: assert property (@(posedge clk) disable iff (!reset_n) // RL5
        (SECOND_CLASS && machine_check_enable && pendingFlags) |=> machineCheckReq)
        else $error("machine check not recalled");
    chk_read_flags: assert property (@(posedge clk) disable iff (!reset_n) // RL12
        (coreHit and (eccEvent.access == EERR_ACC_READ && synUpdate)) |=> machine_check_syndrome.addressValid
            && machine_check_syndrome.loadFlag && machine_check_syndrome.dataReadBusError)
        else $error("read syndrome incomplete");
    chk_fill_flags: assert property (@(posedge clk) disable iff (!reset_n) // RL15
        (coreHit and (isFill && synUpdate)) |=> machine_check_syndrome.addressValid
            && (machine_check_syndrome.dataReadBusError || machine_check_syndrome.instructionReadBusError))
        else $error("line fill syndrome incomplete");
    chk_page_inv: assert property (@(posedge clk) disable iff (!reset_n) // RL10
        flashHit |=> invalidateReq && invalidateMask == (PAGE_INVALIDATE ? pageMask : dwMask))
        else $error("flash invalidate region wrong");
    chk_line_inv: assert property (@(posedge clk) disable iff (!reset_n) // RL11
        fillHit |=> invalidateReq && invalidateMask == lineMask)
        else $error("line not invalidated");
    chk_addr_mode: assert property (@(posedge clk) disable iff (!reset_n) // RL17
        (addrLoad && addressModeSet) |=> machine_check_address == $past(eccEvent.effAddr))
        else $error("effective address not captured");
    chk_ret_capture: assert property (@(posedge clk) disable iff (!reset_n) // RL18
        coreHit |=> (SECOND_CLASS ? machine_check_return_address : save_restore_address) == $past(eccEvent.instAddr))
        else $error("return address not captured");
    chk_ram_capture: assert property (@(posedge clk) disable iff (!reset_n) // RL20
        ramEv |=> ramErrAddr == $past(eccEvent.physAddr))
        else $error("RAM event address not captured");
    chk_ram_flag: assert property (@(posedge clk) disable iff (!reset_n) // RL21
        (ramEv && eccEvent.multiBit) |=> eccStatus[FLG_RAM_NONCORRECTABLE_FLAG_BIT])
        else $error("RAM uncorrectable flag missing");
    chk_flash_flag: assert property (@(posedge clk) disable iff (!reset_n) // RL21
        (flashEv && eccEvent.multiBit) |=> eccStatus[FLG_FLASH_NONCORRECTABLE_FLAG_BIT])
        else $error("flash uncorrectable flag missing");
    chk_single_flag: assert property (@(posedge clk) disable iff (!reset_n) // RL6
        (singleRep && ramEv) |=> eccStatus[FLG_RAM_SINGLE_CORRECTED_FLAG_BIT])
        else $error("RAM single-bit flag missing");
    chk_dma_irq: assert property (@(posedge clk) disable iff (!reset_n) // RL8
        (uncorr && !fromCore && (ramEv || flashEv)) |=> combinedIrq)
        else $error("non-core event raised no interrupt");
    chk_irq_clear: assert property (@(posedge clk) disable iff (!reset_n) // RL23
        (statusClearWrite && statusClearMask == FLG_ALL_MASK && !ramEv && !flashEv) |=> !combinedIrq)
        else $error("interrupt not negated by clear");
endmodule : eerr_ecc_response

// file: verilog/eerr_pkg.sv
// Package for the ECC error response and reporting block.
// Assumes a single 100 MHz clock domain and synchronous inputs.
package eerr_pkg;
    localparam int ADDR_W = 32;
    // Event status flag positions (write-one-to-clear byte)
    localparam int FLG_FLASH_NONCORRECTABLE_FLAG_BIT = 0;
    localparam int FLG_FLASH_SINGLE_CORRECTED_FLAG_BIT = 1;
    localparam int FLG_RAM_NONCORRECTABLE_FLAG_BIT = 4;
    localparam int FLG_RAM_SINGLE_CORRECTED_FLAG_BIT = 5;
    localparam logic [7:0] FLG_ALL_MASK = 8'h33;
    // Cache line and flash page geometry
    localparam int LINE_BYTES = 32;
    localparam int PAGE_BITS = 128;
    localparam int DWORD_BITS = 64;
    localparam int PAGE_ADDR_LSB = $clog2(PAGE_BITS / 8);
    localparam int DWORD_ADDR_LSB = $clog2(DWORD_BITS / 8);
    localparam logic [7:0] CORE_MASTER_ID = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef enum logic [1:0] {EERR_ACC_READ, EERR_ACC_WRITE, EERR_ACC_FETCH, EERR_ACC_LINEFILL} eerr_acc_e;

    typedef struct packed {
        logic        valid;
        logic        multiBit;
        logic        isFlash;
        logic        isDataFill;
        eerr_acc_e   access;
        logic [7:0]  master;
        logic [ADDR_W-1:0] effAddr;
        logic [ADDR_W-1:0] physAddr;
        logic [ADDR_W-1:0] instAddr;
        logic [7:0]  attr;
    } eerr_event_s;

    typedef struct packed {
        logic addressValid;
        logic addressMode;
        logic loadFlag;
        logic fetchFlag;
        logic dataReadBusError;
        logic writeBusError;
        logic instructionReadBusError;
    } eerr_syndrome_s;
endpackage : eerr_pkg

// file: verif/eerr_master_model.sv
// Far-side model: a bus master raising ECC events and the handler that clears syndrome flags.
// Assumes the bench sets its requests at the falling edge of clk.
`timescale 1ns/10ps
module eerr_master_model
    import eerr_pkg::*;
(
    input wire logic clk,
    input wire logic go,
    input wire eerr_event_s req,
    input wire logic clearReq,
    output eerr_event_s eccEvent,
    output eerr_syndrome_s syndromeClear
);
    eerr_event_s lastQ;
    initial lastQ = '0;
    always @(posedge clk) lastQ <= eccEvent;
    // Idle bus toggles every cycle instead of holding the last event
    always_comb
    begin
        eccEvent = ~lastQ;
        eccEvent.valid = 1'b0;
        if (go)
            eccEvent = req;
    end
    assign syndromeClear = clearReq ? '1 : '0;
endmodule : eerr_master_model

// file: verif/testbench.sv
// Self-checking bench for the ECC response block as a first-class core with page invalidation.
// Assumes the far-side model delivers events; inputs change at the falling edge.
`timescale 1ns/10ps
module testbench;
    import eerr_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic go = 1'b0;
    logic clr = 1'b0;
    logic ee = 1'b0;
    logic me = 1'b1;
    logic amode = 1'b0;
    logic stWr = 1'b0;
    logic [7:0] stMask = 8'h00;
    eerr_event_s req = '0;
    eerr_event_s ev;
    eerr_syndrome_s synClr, syn, expSyn;
    logic cs, mc, ds, is, et, irq, inv;
    logic avQ = 1'b0;
    logic [ADDR_W-1:0] invBase, mca, expMca, invMsk, sra, ramAd, flAd;
    logic [7:0] status, ramMst, flMst;
    logic [15:0] rnd = 16'h3f36;
    int mismatches = 0;
    int n_tests = 0;
    int expStat = 0;

    eerr_master_model far_u (.clk(clk), .go(go), .req(req), .clearReq(clr), .eccEvent(ev), .syndromeClear(synClr));
    eerr_ecc_response dut_u (.clk(clk), .reset_n(reset_n), .eccEvent(ev), .external_interrupt_enable(ee),
        .machine_check_enable(me), .singleBitReportEnable(1'b1), .ramReportEnable(1'b1), .flashReportEnable(1'b1),
        .addressModeSet(amode), .statusClearMask(stMask), .statusClearWrite(stWr), .syndromeClear(synClr),
        .checkstop(cs), .machineCheckReq(mc), .dataStorageReq(ds), .instructionStorageReq(is),
        .externalTermination(et), .combinedIrq(irq), .invalidateReq(inv), .invalidateBase(invBase),
        .invalidateMask(invMsk), .machine_check_syndrome(syn), .machine_check_address(mca),
        .machine_check_return_address(), .save_restore_address(sra), .eccStatus(status), .ramErrAddr(ramAd),
        .ramErrMaster(ramMst), .ramErrAttr(), .flashErrAddr(flAd), .flashErrMaster(flMst), .flashErrAttr());

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    task automatic cmp(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : cmp

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // One event, then the exception, status, interrupt and capture responses compared with values expected for it
    task automatic fire(input logic m, input logic f, input eerr_acc_e a, input logic core, input logic fill);
        logic corr;
        logic dAcc;
        @(negedge clk);
        rnd = lfsr(rnd);
        req = '{valid:1'b1, multiBit:m, isFlash:f, isDataFill:fill, access:a,
            master:(core ? CORE_MASTER_ID : {rnd[7:1], 1'b1}), effAddr:{rnd, ~rnd}, physAddr:{~rnd, rnd},
            instAddr:{rnd, rnd}, attr:rnd[15:8]};
        amode = rnd[3];
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        corr = core && m;
        dAcc = a != EERR_ACC_FETCH && !(a == EERR_ACC_LINEFILL && !fill);
        if (m)
            expStat |= f ? 8'h01 : 8'h10;
        cmp(status, expStat);
        cmp(irq, expStat != 0);
        cmp(mc, corr && !ee && me);
        cmp(ds, corr && ee && dAcc);
        cmp(is, corr && ee && !dAcc);
        cmp(cs, corr && !ee && !me);
        if (m)
            cmp(f ? flMst : ramMst, req.master);
        if (m)
            cmp(f ? flAd : ramAd, req.physAddr);
        if (m && (f || a == EERR_ACC_LINEFILL))
            cmp(invMsk, a == EERR_ACC_LINEFILL ? ~(LINE_BYTES - 1) : ~(PAGE_BITS / 8 - 1));
        if (corr)
            cmp(sra, req.instAddr);
        if (m && f)
            cmp({inv, invBase[3:0]}, 5'h10);
        if (corr && ee && dAcc)
            cmp(et, 1'b1);
        if (corr && !ee && me)
        begin
            expSyn = '{addressValid:1'b1, addressMode:amode, loadFlag:(a == EERR_ACC_READ || a == EERR_ACC_WRITE),
                fetchFlag:(a == EERR_ACC_FETCH), dataReadBusError:dAcc, writeBusError:(a == EERR_ACC_WRITE),
                instructionReadBusError:!dAcc};
            cmp(syn, expSyn);
            if (!avQ)
                expMca = amode ? req.effAddr : req.physAddr;
            avQ = 1'b1;
            cmp(mca, expMca);
        end
    endtask : fire

    task automatic clear_all(input logic [7:0] mask, input int left);
        @(negedge clk);
        clr = 1'b1;
        stWr = 1'b1;
        stMask = mask;
        @(negedge clk);
        clr = 1'b0;
        stWr = 1'b0;
        expStat = left;
        avQ = 1'b0;
        cmp(status, left);
        cmp(irq, left != 0);
        cmp(syn.addressValid, 1'b0);
        @(negedge clk);
        cmp(status, left);
    endtask : clear_all

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial forever #5 clk = ~clk;

    initial
    begin
        #100000;
        mismatches++;
        give_verdict();
    end

    initial
    begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 64; i++)
        begin
            ee = i[0];
            me = ee ? rnd[0] : 1'b1;
            fire(i[1], i[2], eerr_acc_e'(i[4:3]), i[5], rnd[1]);
            clear_all(FLG_ALL_MASK, 0);
        end
        ee = 1'b0;
        me = 1'b1;
        fire(1'b1, 1'b0, EERR_ACC_READ, 1'b1, 1'b0);
        fire(1'b1, 1'b1, EERR_ACC_READ, 1'b1, 1'b0);
        clear_all(8'h10, 1);
        clear_all(8'h01, 0);
        me = 1'b0;
        fire(1'b1, 1'b0, EERR_ACC_FETCH, 1'b1, 1'b0);
        @(negedge clk);
        cmp(cs, 1'b1);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        cmp({cs, irq, status}, 10'h000);
        give_verdict();
    end
endmodule : testbench
